// >>> src/grim_cfg.svh
// constants of the remote input mapper: sizes, offsets, field positions, resets, timing
// assumes inclusion by bare name from the package and the design files
`ifndef GRIM_CFG_SVH
`define GRIM_CFG_SVH
// sizes
`define GRIM_SLOTS 16
`define GRIM_INPUTS 32
`define GRIM_ID_CHARS 20
`define GRIM_ID_BITS 160
`define GRIM_ITEMS 64
`define GRIM_DATASETS 4'h8
`define GRIM_APPID_MAX 14'h3fff
// bit selection codes: 0 none, 1..32 predefined, 33..64 user, 65..128 item
`define GRIM_SEL_NONE 8'h00
`define GRIM_SEL_USER_FIRST 8'h21
`define GRIM_SEL_ITEM_FIRST 8'h41
`define GRIM_SEL_LAST 8'h80
// register offsets (byte addresses)
`define GRIM_OFS_IRQ_STAT 12'h000
`define GRIM_OFS_IRQ_MASK 12'h004
`define GRIM_OFS_ONLINE 12'h008
`define GRIM_OFS_VALUE 12'h00c
`define GRIM_SLOT_BASE 12'h200
`define GRIM_SLOT_MASK 12'he00
`define GRIM_INPUT_BASE 12'h400
`define GRIM_INPUT_MASK 12'hf80
`define GRIM_ITEM_BASE 12'h800
`define GRIM_ITEM_MASK 12'hf80
// slot word numbers
`define GRIM_SLOT_W_CFG 3'h5
`define GRIM_SLOT_W_STAT 3'h6
`define GRIM_ID_WORDS 3'h5
// field positions
`define GRIM_APPID_LSB 0
`define GRIM_DSET_LSB 16
`define GRIM_IN_DEV_LSB 0
`define GRIM_IN_SEL_LSB 8
`define GRIM_IN_DEF_LSB 16
`define GRIM_IN_EVT_BIT 20
`define GRIM_ST_TIMER_LSB 16
// reset values
`define GRIM_RST_APPID 14'h0000
`define GRIM_RST_DSET 4'h0
`define GRIM_RST_DEV 4'h0
`define GRIM_RST_SEL 8'h00
// timing: hold timer counts in milliseconds
`define GRIM_CLK_MHZ 200
`define GRIM_TICK_US 1000
`define GRIM_CYC_PER_TICK (`GRIM_CLK_MHZ * `GRIM_TICK_US)
`endif

// >>> src/grim_pkg.sv
// types of the remote input mapper
// assumes grim_cfg.svh on the include path
`include "grim_cfg.svh"
package grim_pkg;
   // default state of a remote input
   typedef enum logic [1:0] {DEF_OFF, DEF_ON, DEF_LATEST_ON, DEF_LATEST_OFF} grim_dflt_t;
   // whole register state of the mapper
   typedef struct packed {
      logic [`GRIM_SLOTS-1:0][`GRIM_ID_BITS-1:0] id;
      logic [`GRIM_SLOTS-1:0][13:0] appid;
      logic [`GRIM_SLOTS-1:0][3:0] dset;
      logic [`GRIM_SLOTS-1:0][15:0] timer;
      logic [`GRIM_SLOTS-1:0] online;
      logic [`GRIM_SLOTS-1:0] test;
      logic [`GRIM_SLOTS-1:0] configuration_revision;
      logic [`GRIM_INPUTS-1:0][3:0] dev;
      logic [`GRIM_INPUTS-1:0][7:0] sel;
      grim_dflt_t [`GRIM_INPUTS-1:0] dflt;
      logic [`GRIM_INPUTS-1:0] evt_en;
      logic [`GRIM_INPUTS-1:0] held;
      logic [`GRIM_INPUTS-1:0] known;
      logic [`GRIM_INPUTS-1:0] value;
      logic [`GRIM_INPUTS-1:0] irq_stat;
      logic [`GRIM_INPUTS-1:0] irq_mask;
      logic [17:0] div;
      logic tick;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic soe_strobe;
      logic [`GRIM_INPUTS-1:0] soe_changed;
   } grim_state_t;
endpackage

// >>> src/grim_item_ram.sv
// small memory holding the configurable items last received per sender
// assumes one clock; read data registered, written by the receive path only
`timescale 1ns/10ps
`default_nettype none
module grim_item_ram #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read port
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   // storage array, no reset needed
   logic [WIDTH-1:0] mem [DEPTH];
   ////////////////////////////////////////////////////////////////////////////////
   // write
   always_ff @(posedge pclk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // registered read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= mem[raddr];
      end
   end
endmodule
`default_nettype wire

// >>> src/grim_top.sv
// remote input mapper: sender table, hold timers, 32 remote inputs, apb registers
// assumes a frame front end on pclk that delivers one parsed message per msg_valid pulse
`timescale 1ns/10ps
`default_nettype none
`include "grim_cfg.svh"
module grim_top #(
   parameter int CYC_PER_TICK = `GRIM_CYC_PER_TICK
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // parsed message from the frame front end
   input wire logic msg_valid,
   input wire logic msg_goose,
   input wire logic [`GRIM_ID_BITS-1:0] msg_id,
   input wire logic [13:0] msg_appid,
   input wire logic [3:0] msg_dataset,
   input wire logic [15:0] msg_ttl,
   input wire logic [31:0] msg_predef,
   input wire logic [31:0] msg_user,
   input wire logic [`GRIM_ITEMS-1:0] msg_items,
   // remote input operands and sender status
   output logic [`GRIM_INPUTS-1:0] remote_in,
   output logic [`GRIM_SLOTS-1:0] sender_online,
   // event recorder feed
   output logic soe_strobe,
   output logic [`GRIM_INPUTS-1:0] soe_changed,
   output logic [`GRIM_INPUTS-1:0] soe_value,
   // interrupt
   output logic irq
);
   import grim_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // state and helpers
   grim_state_t s; // registered state
   grim_state_t nxt; // next state
   logic [`GRIM_SLOTS-1:0] acc; // slot accepted this message
   logic mem_we; // item store write
   logic [3:0] mem_waddr; // item store slot
   logic [63:0] mem_rdata; // item store read word pair
   // default bit of a default-state choice
   function automatic logic def_bit(input grim_dflt_t d);
      def_bit = (d == DEF_ON) || (d == DEF_LATEST_ON);
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // received items per sender, readable over the bus
   grim_item_ram #(
      .WIDTH(64),
      .DEPTH(`GRIM_SLOTS),
      .AW(4)
   ) u_items (
      .pclk(pclk),
      .presetn(presetn),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(msg_items),
      .raddr(paddr[6:3]),
      .rdata(mem_rdata)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      int k;
      int i;
      int w;
      logic [3:0] sl;
      logic [7:0] ix;
      logic take;
      logic bv;
      logic setup;
      logic access;
      logic wr;
      logic [31:0] rd;
      logic err;
      logic [`GRIM_INPUTS-1:0] ev;
      k = 0;
      i = 0;
      w = 0;
      sl = 4'h0;
      ix = 8'h00;
      take = 1'b0;
      bv = 1'b0;
      rd = 32'h0000_0000;
      err = 1'b0;
      ev = '0;
      nxt = s;
      acc = '0;
      mem_we = 1'b0;
      mem_waddr = 4'h0;
      setup = psel && !penable;
      access = psel && penable;
      wr = access && pwrite && s.pready;
      // millisecond tick divider
      nxt.tick = 1'b0;
      if (s.div == 18'(CYC_PER_TICK - 1))
      begin
         nxt.div = 18'h00000;
         nxt.tick = 1'b1;
      end
      else
      begin
         nxt.div = s.div + 18'h00001;
      end
      // sender matching and hold timers
      for (k = `GRIM_SLOTS - 1; k >= 0; k--)
      begin
         // exact id, app id only for goose
         acc[k] = msg_valid && (msg_id == s.id[k]) &&
                  (!msg_goose || (msg_appid == s.appid[k]));
         if (acc[k])
         begin
            nxt.timer[k] = msg_ttl;
            nxt.test[k] = msg_predef[0];
            nxt.configuration_revision[k] = msg_predef[1];
            mem_we = 1'b1;
            mem_waddr = 4'(k);
         end
         else if (s.tick && (s.timer[k] != 16'h0000))
         begin
            nxt.timer[k] = s.timer[k] - 16'h0001;
         end
      end
      // input latches follow their sender
      for (i = 0; i < `GRIM_INPUTS; i++)
      begin
         sl = s.dev[i];
         ix = s.sel[i] - 8'h01;
         take = 1'b0;
         bv = 1'b0;
         if (s.sel[i] == `GRIM_SEL_NONE || s.sel[i] > `GRIM_SEL_LAST)
         begin
            take = 1'b0;
         end
         else if (s.sel[i] < `GRIM_SEL_ITEM_FIRST)
         begin
            // fixed layout sources need a fixed-dataset slot
            take = (s.dset[sl] == 4'h0);
            bv = (s.sel[i] < `GRIM_SEL_USER_FIRST) ? msg_predef[ix[4:0]] :
                 msg_user[ix[4:0]];
         end
         else
         begin
            // items need a goose message of the slot's dataset
            take = (s.dset[sl] != 4'h0) && msg_goose && (msg_dataset == s.dset[sl]);
            bv = msg_items[ix[5:0]];
         end
         if (acc[sl] && take)
         begin
            nxt.held[i] = bv;
            nxt.known[i] = 1'b1;
         end
      end
      // apb answer, pready one access cycle late
      nxt.pready = 1'b0;
      if (access && !s.pready)
      begin
         nxt.pready = 1'b1;
         if (paddr == `GRIM_OFS_IRQ_STAT)
         begin
            rd = s.irq_stat;
         end
         else if (paddr == `GRIM_OFS_IRQ_MASK)
         begin
            rd = s.irq_mask;
         end
         else if (paddr == `GRIM_OFS_ONLINE)
         begin
            rd = {16'h0000, s.online};
         end
         else if (paddr == `GRIM_OFS_VALUE)
         begin
            rd = s.value;
         end
         else if ((paddr & `GRIM_SLOT_MASK) == `GRIM_SLOT_BASE)
         begin
            sl = paddr[8:5];
            if (paddr[4:2] < `GRIM_ID_WORDS)
            begin
               w = int'(paddr[4:2]);
               rd = s.id[sl][w*32 +: 32];
            end
            else if (paddr[4:2] == `GRIM_SLOT_W_CFG)
            begin
               rd[`GRIM_APPID_LSB +: 14] = s.appid[sl];
               rd[`GRIM_DSET_LSB +: 4] = s.dset[sl];
            end
            else if (paddr[4:2] == `GRIM_SLOT_W_STAT)
            begin
               rd[`GRIM_ST_TIMER_LSB +: 16] = s.timer[sl];
               rd[2:0] = {s.configuration_revision[sl], s.test[sl], s.online[sl]};
            end
            else
            begin
               err = 1'b1;
            end
         end
         else if ((paddr & `GRIM_INPUT_MASK) == `GRIM_INPUT_BASE)
         begin
            i = int'(paddr[6:2]);
            rd[`GRIM_IN_DEV_LSB +: 4] = s.dev[i];
            rd[`GRIM_IN_SEL_LSB +: 8] = s.sel[i];
            rd[`GRIM_IN_DEF_LSB +: 2] = s.dflt[i];
            rd[`GRIM_IN_EVT_BIT] = s.evt_en[i];
         end
         else if ((paddr & `GRIM_ITEM_MASK) == `GRIM_ITEM_BASE)
         begin
            rd = paddr[2] ? mem_rdata[63:32] : mem_rdata[31:0];
         end
         else
         begin
            err = 1'b1;
         end
         nxt.prdata = pwrite ? 32'h0000_0000 : rd;
         nxt.pslverr = err;
      end
      else if (setup)
      begin
         nxt.pslverr = 1'b0;
      end
      // writes land on the edge that completes the access
      if (wr)
      begin
         if (paddr == `GRIM_OFS_IRQ_MASK)
         begin
            nxt.irq_mask = pwdata;
         end
         else if ((paddr & `GRIM_SLOT_MASK) == `GRIM_SLOT_BASE)
         begin
            sl = paddr[8:5];
            if (paddr[4:2] < `GRIM_ID_WORDS)
            begin
               w = int'(paddr[4:2]);
               nxt.id[sl][w*32 +: 32] = pwdata;
            end
            else if (paddr[4:2] == `GRIM_SLOT_W_CFG)
            begin
               nxt.appid[sl] = pwdata[`GRIM_APPID_LSB +: 14];
               if (pwdata[`GRIM_DSET_LSB +: 4] <= `GRIM_DATASETS)
               begin
                  nxt.dset[sl] = pwdata[`GRIM_DSET_LSB +: 4];
               end
            end
         end
         else if ((paddr & `GRIM_INPUT_MASK) == `GRIM_INPUT_BASE)
         begin
            i = int'(paddr[6:2]);
            nxt.dev[i] = pwdata[`GRIM_IN_DEV_LSB +: 4];
            nxt.sel[i] = pwdata[`GRIM_IN_SEL_LSB +: 8];
            nxt.dflt[i] = grim_dflt_t'(pwdata[`GRIM_IN_DEF_LSB +: 2]);
            nxt.evt_en[i] = pwdata[`GRIM_IN_EVT_BIT];
         end
      end
      // online status and input values from the next state
      for (k = 0; k < `GRIM_SLOTS; k++)
      begin
         nxt.online[k] = (nxt.timer[k] != 16'h0000);
      end
      for (i = 0; i < `GRIM_INPUTS; i++)
      begin
         if (nxt.sel[i] == `GRIM_SEL_NONE || nxt.sel[i] > `GRIM_SEL_LAST)
         begin
            nxt.value[i] = def_bit(nxt.dflt[i]);
         end
         else if (nxt.known[i] && nxt.online[nxt.dev[i]])
         begin
            nxt.value[i] = nxt.held[i];
         end
         else if (nxt.known[i] && (nxt.dflt[i] == DEF_LATEST_ON ||
                                   nxt.dflt[i] == DEF_LATEST_OFF))
         begin
            nxt.value[i] = nxt.held[i];
         end
         else
         begin
            nxt.value[i] = def_bit(nxt.dflt[i]);
         end
      end
      // event logging and sticky status, set beats clear
      ev = (nxt.value ^ s.value) & s.evt_en;
      nxt.soe_strobe = |ev;
      nxt.soe_changed = ev;
      nxt.irq_stat = s.irq_stat;
      if (wr && paddr == `GRIM_OFS_IRQ_STAT)
      begin
         nxt.irq_stat = s.irq_stat & ~pwdata;
      end
      nxt.irq_stat = nxt.irq_stat | ev;
      nxt.irq = |(nxt.irq_stat & nxt.irq_mask);
   end
   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= '0;
      end
      else
      begin
         s <= nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign remote_in = s.value;
   assign sender_online = s.online;
   assign soe_strobe = s.soe_strobe;
   assign soe_changed = s.soe_changed;
   assign soe_value = s.value;
   assign irq = s.irq;
   ////////////////////////////////////////////////////////////////////////////////
   // checks
   a_timer_load: assert property (@(posedge pclk) disable iff (!presetn)
      acc[0] |=> s.timer[0] == $past(msg_ttl))
      else $error("hold timer not loaded from time-to-live");
   a_online_flag: assert property (@(posedge pclk) disable iff (!presetn)
      s.online[3] == (s.timer[3] != 16'h0000))
      else $error("online flag disagrees with hold timer");
   a_foreign_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (msg_valid && acc == '0) |=> $stable(s.held) && $stable(s.known))
      else $error("unmatched message changed an input");
   a_appid_check: assert property (@(posedge pclk) disable iff (!presetn)
      (msg_valid && msg_goose && msg_id == s.id[1] && msg_appid != s.appid[1]) |-> !acc[1])
      else $error("goose with wrong app id accepted");
   a_none_default: assert property (@(posedge pclk) disable iff (!presetn)
      s.sel[0] == `GRIM_SEL_NONE |-> s.value[0] == def_bit(s.dflt[0]))
      else $error("input with no source left its default");
   a_offline_default: assert property (@(posedge pclk) disable iff (!presetn)
      (!s.online[s.dev[2]] && s.sel[2] != `GRIM_SEL_NONE && s.dflt[2] == DEF_ON) |->
      s.value[2] == 1'b1)
      else $error("offline input with on default not high");
   a_latest_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      (s.known[4] && !s.online[s.dev[4]] && s.dflt[4] == DEF_LATEST_OFF &&
       s.sel[4] != `GRIM_SEL_NONE && s.sel[4] <= `GRIM_SEL_LAST) |-> s.value[4] == s.held[4])
      else $error("latest mode did not freeze the value");
   a_event_logged: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(s.evt_en[5]) && s.value[5] != $past(s.value[5])) |->
      s.soe_strobe && s.soe_changed[5] && s.irq_stat[5])
      else $error("enabled input change not logged");
   a_known_cause: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s.known[6]) |-> $past(acc[s.dev[6]]))
      else $error("input became known without a message");
   a_item_store: assert property (@(posedge pclk) disable iff (!presetn)
      acc[2] |-> mem_we)
      else $error("accepted items not stored");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      (s.irq_stat & s.irq_mask) == '0 |-> !s.irq)
      else $error("interrupt high with nothing pending");
endmodule
`default_nettype wire

// >>> sim/grim_sender.sv
// remote sender model: puts one parsed message on the msg port set per call
// assumes the caller runs on pclk and calls send between edges
`timescale 1ns/10ps
`default_nettype none
`include "grim_cfg.svh"
module grim_sender (
   // clock
   input wire logic pclk,
   // parsed message toward the mapper
   output logic msg_valid,
   output logic msg_goose,
   output logic [`GRIM_ID_BITS-1:0] msg_id,
   output logic [13:0] msg_appid,
   output logic [3:0] msg_dataset,
   output logic [15:0] msg_ttl,
   output logic [31:0] msg_predef,
   output logic [31:0] msg_user,
   output logic [`GRIM_ITEMS-1:0] msg_items
);
   ////////////////////////////////////////////////////////////////////////////////
   // idle values at time zero
   initial
   begin
      {msg_valid, msg_goose, msg_id, msg_appid, msg_dataset} = '0;
      {msg_ttl, msg_predef, msg_user, msg_items} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one message pulse; fields inverted afterwards so stale data never looks valid
   task automatic send(input logic [`GRIM_ID_BITS-1:0] id, input logic goose,
                       input logic [13:0] app, input logic [3:0] dset, input logic [15:0] ttl,
                       input logic test, input logic conf, input logic [29:0] hi,
                       input logic [31:0] user, input logic [`GRIM_ITEMS-1:0] items);
      @(posedge pclk);
      msg_valid <= 1'b1;
      msg_goose <= goose;
      msg_id <= id;
      msg_appid <= app;
      msg_dataset <= dset;
      msg_ttl <= ttl;
      msg_predef <= {hi, conf, test};
      msg_user <= user;
      msg_items <= items;
      @(posedge pclk);
      msg_valid <= 1'b0;
      msg_goose <= ~goose;
      msg_id <= ~id;
      msg_appid <= ~app;
      msg_dataset <= ~dset;
      msg_ttl <= ~ttl;
      msg_predef <= ~{hi, conf, test};
      msg_user <= ~user;
      msg_items <= ~items;
   endtask
endmodule
`default_nettype wire

// >>> sim/test_grim_top.sv
// bench of the remote input mapper: apb reads checked through a queue of notes
// assumes grim_top, grim_sender and grim_cfg.svh compiled alongside
`timescale 1ns/10ps
`default_nettype none
`include "grim_cfg.svh"
module test_grim_top;
   import grim_pkg::*;
   // apb and clock
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   // message port
   logic msg_valid, msg_goose;
   logic [`GRIM_ID_BITS-1:0] msg_id, id_a, id_b;
   logic [13:0] msg_appid, app_a, app_b;
   logic [3:0] msg_dataset;
   logic [15:0] msg_ttl;
   logic [31:0] msg_predef, msg_user;
   logic [`GRIM_ITEMS-1:0] msg_items, items;
   // outputs watched beside the register reads
   logic [31:0] remote_in, soe_changed, soe_value, soe_seen;
   logic [15:0] sender_online;
   logic soe_strobe;
   // bookkeeping
   logic [32:0] exp_q[$];
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   integer seed;
   // input setups: dev, sel, default, events for inputs 0..9
   logic [31:0] cfg [10] = '{32'h0010_0100, 32'h0002_2500, 32'h0001_0000, 32'h0003_0201,
      32'h0001_0300, 32'h0000_4801, 32'h0000_2000, 32'h0000_2100, 32'h0000_4000, 32'h0001_8100};
   ////////////////////////////////////////////////////////////////////////////////
   // design and sender, tick shortened to ten cycles
   grim_top #(.CYC_PER_TICK(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .msg_valid(msg_valid), .msg_goose(msg_goose),
      .msg_id(msg_id), .msg_appid(msg_appid), .msg_dataset(msg_dataset), .msg_ttl(msg_ttl),
      .msg_predef(msg_predef), .msg_user(msg_user), .msg_items(msg_items),
      .remote_in(remote_in), .sender_online(sender_online), .soe_strobe(soe_strobe),
      .soe_changed(soe_changed), .soe_value(soe_value), .irq(irq));
   grim_sender u_snd (.pclk(pclk), .msg_valid(msg_valid), .msg_goose(msg_goose),
      .msg_id(msg_id), .msg_appid(msg_appid), .msg_dataset(msg_dataset), .msg_ttl(msg_ttl),
      .msg_predef(msg_predef), .msg_user(msg_user), .msg_items(msg_items));
   ////////////////////////////////////////////////////////////////////////////////
   // clock, 5 ns period
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;
   // compare and count
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic conclude();
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one apb transfer; reads leave their expected {pslverr, prdata} in the queue
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] exp);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr)
         exp_q.push_back(exp);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, {1'b0, exp});
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   // message from a slot 0 style sender with fixed predefined pairs
   task automatic msg0(input logic [`GRIM_ID_BITS-1:0] id, input logic goose,
                       input logic [13:0] app, input logic [31:0] user);
      u_snd.send(id, goose, app, 4'h0, 16'h0014, 1'b1, 1'b0, 30'h2000_0000, user, items);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // read completions checked against the oldest note
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         // operand and online pins must agree with their register views
         if (paddr == 12'h00c)
         begin
            check({1'b0, remote_in}, exp_q[0]);
            check({1'b0, soe_value}, exp_q[0]);
         end
         if (paddr == 12'h008)
            check({17'h0, sender_online}, exp_q[0]);
         check({pslverr, prdata}, exp_q.pop_front());
      end
   // every input that raised an event record
   always @(posedge pclk)
      if (soe_strobe === 1'b1)
         soe_seen <= soe_seen | soe_changed;
   // hang guard
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      seed = 32'h824e;
      soe_seen = '0;
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      id_a = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      id_b = id_a ^ 160'h5a;
      app_a = 14'($random(seed));
      app_b = 14'($random(seed));
      items = {$random(seed), $random(seed)};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and an unmapped word
      rd(12'h214, 32'h0);
      rd(12'h400, 32'h0);
      rd(12'h008, 32'h0);
      apb(1'b0, 12'h21c, 32'h0, {1'b1, 32'h0});
      // slot ids, slot config, input setups
      for (int w = 0; w < 5; w++)
      begin
         wr(12'h200 + 12'(w * 4), id_a[w * 32 +: 32]);
         wr(12'h220 + 12'(w * 4), id_b[w * 32 +: 32]);
      end
      wr(12'h214, {18'h0, app_a});
      wr(12'h234, {12'h0, 4'h3, 2'h0, app_b});
      for (int i = 0; i < 10; i++)
         wr(12'h400 + 12'(i * 4), cfg[i]);
      rd(12'h00c, 32'h216);
      // last char differs, then goose with a wrong app id: both ignored
      msg0(id_a ^ (160'h1 << 152), 1'b0, app_a, 32'h8000_0011);
      msg0(id_a, 1'b1, app_a ^ 14'h1, 32'h8000_0011);
      rd(12'h00c, 32'h216);
      // gsse ignores the app id
      msg0(id_a, 1'b0, app_a ^ 14'h1, 32'h8000_0001);
      rd(12'h00c, 32'h3c5);
      rd(12'h008, 32'h1);
      rd(12'h000, 32'h1);
      // refresh before expiry keeps the sender online past the first time-to-live
      repeat (130) @(posedge pclk);
      msg0(id_a, 1'b1, app_a, 32'h8000_0011);
      rd(12'h00c, 32'h3c7);
      repeat (150) @(posedge pclk);
      rd(12'h008, 32'h1);
      repeat (250) @(posedge pclk);
      rd(12'h008, 32'h0);
      rd(12'h00c, 32'h216);
      // interrupt: masked, unmasked, cleared
      @(negedge pclk);
      check({32'h0, irq}, 33'h0);
      wr(12'h004, 32'h1);
      repeat (2) @(negedge pclk);
      check({32'h0, irq}, 33'h1);
      wr(12'h000, 32'h1);
      rd(12'h000, 32'h0);
      @(negedge pclk);
      check({32'h0, irq}, 33'h0);
      // configurable dataset 3 on slot 1; fixed selection there stays unused
      u_snd.send(id_b, 1'b1, app_b, 4'h3, 16'h00c8, 1'b1, 1'b1, 30'h0, 32'h0, items);
      rd(12'h808, items[31:0]);
      rd(12'h80c, items[63:32]);
      rd(12'h00c, 32'h216 | {26'h0, items[7], 5'h0});
      // other dataset number leaves item inputs alone
      u_snd.send(id_b, 1'b1, app_b, 4'h4, 16'h00c8, 1'b1, 1'b1, 30'h0, 32'h0, ~items);
      rd(12'h00c, 32'h216 | {26'h0, items[7], 5'h0});
      rd(12'h008, 32'h2);
      // only input 0 logs events: it rose on the first accepted message and fell on expiry
      check({1'b0, soe_seen}, 33'h1);
      conclude();
   end
endmodule
`default_nettype wire
